// ===== qpcd_pkg.sv
// Package for the quad potentiometer command decoder.
// Assumes a single 10 MHz core clock; every time is held in its own unit
// and turned into a cycle count here.
package qpcd_pkg;

	// Core clock
	localparam int CLK_HZ = 10_000_000;

	// Nonvolatile write cycle, typical figure
	localparam int NV_WRITE_MS = 5;
	localparam int NV_WRITE_CYC = NV_WRITE_MS * (CLK_HZ / 1000);

	// Wiper settle delay after a setting-to-wiper copy
	localparam int WIPER_SETTLE_NS = 1000;
	localparam int SETTLE_CYC_RAW = (WIPER_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;

	// Geometry
	localparam int NUM_POTS = 4;
	localparam int NUM_REGS = 4;
	localparam int NUM_TAPS = 64;
	localparam int POS_W = 6;

	// Slave address byte fields
	localparam int ADDR_TYPE_LSB = 4;
	localparam int ADDR_PIN_W = 4;

	// Instruction byte fields
	localparam int OPC_LSB = 4;
	localparam int POT_LSB = 2;
	localparam int RSEL_LSB = 0;

	// Data byte fields
	localparam int DATA_OFF_BIT = 6;
	localparam int DATA_CHAIN_BIT = 7;
	localparam logic [5:0] POS_MAX = 6'h3f;
	localparam logic [5:0] POS_MIN = 6'h00;

	// Reset values
	localparam logic [7:0] WCR_RESET = 8'h00;
	localparam logic [7:0] SET_RESET = 8'h00;

	// Opcodes
	localparam logic [3:0] OP_RD_WCR = 4'h9;
	localparam logic [3:0] OP_WR_WCR = 4'ha;
	localparam logic [3:0] OP_RD_SET = 4'hb;
	localparam logic [3:0] OP_WR_SET = 4'hc;
	localparam logic [3:0] OP_COPY_S2W = 4'hd;
	localparam logic [3:0] OP_COPY_W2S = 4'he;
	localparam logic [3:0] OP_GCOPY_S2W = 4'h1;
	localparam logic [3:0] OP_GCOPY_W2S = 4'h8;
	localparam logic [3:0] OP_INCDEC = 4'h2;

	// Serial engine states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_INSTR,
		ST_ACK_INSTR,
		ST_DATA_RX,
		ST_ACK_DATA,
		ST_DATA_TX,
		ST_MASTER_ACK,
		ST_INCDEC,
		ST_DONE
	} qpcd_state_t;

endpackage

// ===== qpcd_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to core_clk and change slowly.
module qpcd_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk, // Core clock
	input wire logic resetn, // Synchronous reset, active low
	input wire logic [WIDTH-1:0] async_in, // Raw pin levels
	output logic [WIDTH-1:0] sync_out // Levels safe for core logic
);

	logic [WIDTH-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			meta <= '1;
			sync_out <= '1;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule

// ===== qpcd_decoder.sv
// Command decoder behind the two-wire slave port of a quad potentiometer.
// Assumes scl, sda and the address pins are asynchronous pins; sda is an
// open-drain line resolved outside from sda_out and sda_oe.
//
// Summary of operation
// - A stop ending a nonvolatile write starts the internal write cycle.
// - Serial inputs are ignored while the internal write is running.
// - No acknowledge to the slave address while the write is busy.
// - After the write finishes, the slave address is acknowledged again.
// - Upper four bits of the instruction byte are the opcode.
// - Next two bits pick the pot, lowest two pick its register.
// - Four instructions are two-byte copies between wiper and setting registers.
// - Setting-to-wiper copy is volatile; the wiper follows after a settle delay.
// - Wiper-to-setting copy is a nonvolatile write needing the write time.
// - Copies act on one selected pot or globally on all four.
// - Register reads and writes use address, instruction, data bytes.
// - Opcode 1001 reads the selected wiper register; register bits ignored.
// - Opcode 1010 writes the selected wiper register; register bits ignored.
// - Opcode 1011 reads and 1100 writes the chosen setting register.
// - Opcode 1101 copies the chosen setting register into the wiper register.
// - Opcode 1110 copies the wiper register into the chosen setting register.
// - Opcode 0001 copies chosen setting register to wiper on every pot.
// - Opcode 1000 copies every wiper into its chosen setting register.
// - Opcode 0010 enters increment/decrement mode after the instruction acknowledge.
// - In that mode a clock high pulse with data high steps up.
// - In that mode a clock high pulse with data low steps down.
// - Address upper nibble must match the type code, lower nibble the pins.
// - Acknowledge after address, after instruction, and after a data byte.
// - Six low wiper bits select exactly one of 64 tap switches.
// - Data byte holds position in bits 5:0, wiper-off bit 6, chain bit 7.
module qpcd_decoder
	import qpcd_pkg::*;
#(
	parameter logic [3:0] DEV_TYPE = 4'ha, // Device type code, value arbitrary
	parameter int NV_CYCLES = NV_WRITE_CYC // Internal write duration in cycles
) (
	input wire logic core_clk, // Core clock, 10 MHz
	input wire logic resetn, // Synchronous reset, active low
	input wire logic scl_in, // Serial clock pin from the master
	input wire logic sda_in, // Serial data pin level
	output logic sda_out, // Serial data drive value, always low
	output logic sda_oe, // High while pulling serial data low
	input wire logic [ADDR_PIN_W-1:0] addr_pins, // Device address straps
	output logic [NUM_POTS*NUM_TAPS-1:0] wiper_tap, // One-hot tap per pot
	output logic [NUM_POTS-1:0] wiper_off_bit, // Wiper isolated per pot
	output logic [NUM_POTS-1:0] chain_enable_bit, // Cascade enable per pot
	output logic nv_busy, // Internal nonvolatile write in progress
	output logic step_mode // Increment/decrement mode active
);

	localparam int NVW = $clog2(NV_CYCLES + 1);
	localparam int STW = $clog2(SETTLE_CYC + 1);

	logic scl_s;
	logic sda_s;
	logic [ADDR_PIN_W-1:0] addr_s;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;

	qpcd_state_t state;
	logic [7:0] shreg;
	logic [3:0] bitcnt;
	logic [7:0] instr;
	logic drive_low;
	logic byte_done;

	logic [3:0] opc;
	logic [1:0] pot;
	logic [1:0] rsel;
	logic glob;
	logic opc_ok;
	logic addr_hit;
	logic [7:0] tx_byte;

	logic ev_wdata;
	logic ev_copy_s2w;
	logic ev_copy_w2s;
	logic ev_step;

	logic [7:0] wiper_position_reg [NUM_POTS];
	logic [7:0] setting_regs [NUM_POTS*NUM_REGS];
	logic [7:0] wiper_shown [NUM_POTS];
	logic [STW-1:0] settle_cnt;
	logic [NVW-1:0] nv_cnt;
	logic nv_pend;

	// Pins cross into the core clock through two flops each
	qpcd_sync #(
		.WIDTH(ADDR_PIN_W + 2)
	) u_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.async_in({scl_in, sda_in, addr_pins}),
		.sync_out({scl_s, sda_s, addr_s})
	);

	// Previous synchronised levels for edge and condition detection
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_q;
	assign scl_fall = !scl_s && scl_q;
	// Data moving while the clock stays high marks start and stop
	assign start_ev = scl_s && scl_q && sda_q && !sda_s;
	assign stop_ev = scl_s && scl_q && !sda_q && sda_s;

	// Instruction fields
	assign opc = instr[OPC_LSB +: 4];
	assign pot = instr[POT_LSB +: 2];
	assign rsel = instr[RSEL_LSB +: 2];
	// Global copies ignore the pot field
	assign glob = (opc == OP_GCOPY_S2W) || (opc == OP_GCOPY_W2S);

	assign byte_done = scl_fall && (bitcnt == 4'h8);
	assign addr_hit = (shreg[ADDR_TYPE_LSB +: 4] == DEV_TYPE)
		&& (shreg[ADDR_PIN_W-1:0] == addr_s);

	// Only the nine defined opcodes are acknowledged
	always_comb begin
		case (shreg[OPC_LSB +: 4])
			OP_RD_WCR, OP_WR_WCR, OP_RD_SET, OP_WR_SET: opc_ok = 1'b1;
			OP_COPY_S2W, OP_COPY_W2S, OP_GCOPY_S2W, OP_GCOPY_W2S: opc_ok = 1'b1;
			OP_INCDEC: opc_ok = 1'b1;
			default: opc_ok = 1'b0;
		endcase
	end

	// Read source: wiper register ignores the register bits
	assign tx_byte = (opc == OP_RD_WCR) ? wiper_position_reg[pot]
		: setting_regs[{pot, rsel}];

	// Register file events
	assign ev_wdata = (state == ST_DATA_RX) && byte_done;
	assign ev_copy_s2w = (state == ST_ACK_INSTR) && scl_fall
		&& ((opc == OP_COPY_S2W) || (opc == OP_GCOPY_S2W));
	assign ev_copy_w2s = (state == ST_ACK_INSTR) && scl_fall
		&& ((opc == OP_COPY_W2S) || (opc == OP_GCOPY_W2S));
	// Each clock high pulse counts once, at its rising edge
	assign ev_step = (state == ST_INCDEC) && scl_rise;

	// Serial engine; the busy write cycle holds it idle and deaf
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state <= ST_IDLE;
			shreg <= 8'h00;
			bitcnt <= 4'h0;
			instr <= 8'h00;
			drive_low <= 1'b0;
		end else if (nv_busy) begin
			state <= ST_IDLE;
			drive_low <= 1'b0;
			bitcnt <= 4'h0;
		end else if (start_ev) begin
			// A repeated start restarts addressing from any state
			state <= ST_ADDR;
			bitcnt <= 4'h0;
			drive_low <= 1'b0;
		end else if (stop_ev) begin
			state <= ST_IDLE;
			drive_low <= 1'b0;
		end else begin
			case (state)
				ST_ADDR, ST_INSTR, ST_DATA_RX: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda_s};
						bitcnt <= bitcnt + 4'h1;
					end
					if (byte_done) begin
						bitcnt <= 4'h0;
						if (state == ST_ADDR) begin
							if (addr_hit) begin
								drive_low <= 1'b1;
								state <= ST_ACK_ADDR;
							end else begin
								state <= ST_IDLE;
							end
						end else if (state == ST_INSTR) begin
							instr <= shreg;
							if (opc_ok) begin
								drive_low <= 1'b1;
								state <= ST_ACK_INSTR;
							end else begin
								state <= ST_IDLE;
							end
						end else begin
							drive_low <= 1'b1;
							state <= ST_ACK_DATA;
						end
					end
				end
				ST_ACK_ADDR: begin
					if (scl_fall) begin
						drive_low <= 1'b0;
						state <= ST_INSTR;
					end
				end
				ST_ACK_INSTR: begin
					if (scl_fall) begin
						drive_low <= 1'b0;
						bitcnt <= 4'h0;
						case (opc)
							OP_RD_WCR, OP_RD_SET: begin
								// First data bit goes out as the acknowledge ends
								shreg <= tx_byte;
								drive_low <= !tx_byte[7];
								state <= ST_DATA_TX;
							end
							OP_WR_WCR, OP_WR_SET: state <= ST_DATA_RX;
							OP_INCDEC: state <= ST_INCDEC;
							default: state <= ST_DONE;
						endcase
					end
				end
				ST_DATA_TX: begin
					if (scl_rise) begin
						bitcnt <= bitcnt + 4'h1;
					end
					if (byte_done) begin
						drive_low <= 1'b0;
						state <= ST_MASTER_ACK;
					end else if (scl_fall) begin
						shreg <= {shreg[6:0], 1'b0};
						drive_low <= !shreg[6];
					end
				end
				ST_ACK_DATA: begin
					if (scl_fall) begin
						drive_low <= 1'b0;
						state <= ST_DONE;
					end
				end
				ST_MASTER_ACK: begin
					if (scl_fall) begin
						state <= ST_DONE;
					end
				end
				ST_INCDEC, ST_DONE, ST_IDLE: begin
					drive_low <= 1'b0;
				end
				default: begin
					state <= ST_IDLE;
					drive_low <= 1'b0;
				end
			endcase
		end
	end

	// Wiper and setting registers, all writers in one place
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			for (int p = 0; p < NUM_POTS; p++) begin
				wiper_position_reg[p] <= WCR_RESET;
			end
			for (int r = 0; r < NUM_POTS * NUM_REGS; r++) begin
				setting_regs[r] <= SET_RESET;
			end
		end else begin
			if (ev_wdata && (opc == OP_WR_WCR)) begin
				wiper_position_reg[pot] <= shreg;
			end
			if (ev_wdata && (opc == OP_WR_SET)) begin
				setting_regs[{pot, rsel}] <= shreg;
			end
			for (int p = 0; p < NUM_POTS; p++) begin
				if (ev_copy_s2w && (glob || (2'(p) == pot))) begin
					wiper_position_reg[p] <= setting_regs[{2'(p), rsel}];
				end
				if (ev_copy_w2s && (glob || (2'(p) == pot))) begin
					setting_regs[{2'(p), rsel}] <= wiper_position_reg[p];
				end
			end
			if (ev_step) begin
				// Ends saturate rather than wrap
				if (sda_s && (wiper_position_reg[pot][5:0] != POS_MAX)) begin
					wiper_position_reg[pot][5:0] <= wiper_position_reg[pot][5:0] + 6'h01;
				end else if (!sda_s && (wiper_position_reg[pot][5:0] != POS_MIN)) begin
					wiper_position_reg[pot][5:0] <= wiper_position_reg[pot][5:0] - 6'h01;
				end
			end
		end
	end

	// Settle delay: the taps hold their old position for a while after a copy
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			settle_cnt <= '0;
		end else if (ev_copy_s2w) begin
			settle_cnt <= STW'(SETTLE_CYC);
		end else if (settle_cnt != '0) begin
			settle_cnt <= settle_cnt - STW'(1);
		end
	end

	// Shown wiper value tracks the register once no settle is pending
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			for (int p = 0; p < NUM_POTS; p++) begin
				wiper_shown[p] <= WCR_RESET;
			end
		end else if ((settle_cnt == '0) && !ev_copy_s2w) begin
			for (int p = 0; p < NUM_POTS; p++) begin
				wiper_shown[p] <= wiper_position_reg[p];
			end
		end
	end

	// Tap decode per pot; a disabled wiper opens every switch
	generate
		for (genvar g = 0; g < NUM_POTS; g++) begin : g_pot
			always_ff @(posedge core_clk) begin
				if (!resetn) begin
					wiper_tap[g*NUM_TAPS +: NUM_TAPS] <= '0;
					wiper_off_bit[g] <= 1'b0;
					chain_enable_bit[g] <= 1'b0;
				end else begin
					wiper_tap[g*NUM_TAPS +: NUM_TAPS] <= wiper_shown[g][DATA_OFF_BIT] ? 64'h0
						: (64'h1 << wiper_shown[g][POS_W-1:0]);
					wiper_off_bit[g] <= wiper_shown[g][DATA_OFF_BIT];
					chain_enable_bit[g] <= wiper_shown[g][DATA_CHAIN_BIT];
				end
			end
		end
	endgenerate

	// Pending nonvolatile change, committed to the write cycle at stop
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			nv_pend <= 1'b0;
		end else if (stop_ev && !nv_busy) begin
			nv_pend <= 1'b0;
		end else if ((ev_wdata && (opc == OP_WR_SET)) || ev_copy_w2s) begin
			nv_pend <= 1'b1;
		end
	end

	// Internal write timer; polling gets no acknowledge until it expires
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			nv_cnt <= '0;
		end else if (stop_ev && nv_pend && !nv_busy) begin
			nv_cnt <= NVW'(NV_CYCLES);
		end else if (nv_cnt != '0) begin
			nv_cnt <= nv_cnt - NVW'(1);
		end
	end

	assign nv_busy = (nv_cnt != '0);
	assign step_mode = (state == ST_INCDEC);
	// Open drain: only ever pull low
	assign sda_out = 1'b0;
	assign sda_oe = drive_low;

endmodule

// ===== qpcd_decoder_assertions.sv
// Port checker for the pot command decoder.
// Assumes one clock, core_clk, with resetn synchronous.
module qpcd_decoder_chk
	import qpcd_pkg::*;
#(
	parameter int NV_CYCLES = NV_WRITE_CYC // Write cycles
) (
	input wire logic core_clk, // Clock
	input wire logic resetn, // Reset
	input wire logic scl_in, // Serial clock
	input wire logic sda_in, // Serial data
	input wire logic sda_out, // Drive value
	input wire logic sda_oe, // Pull enable
	input wire logic [ADDR_PIN_W-1:0] addr_pins, // Straps
	input wire logic [NUM_POTS*NUM_TAPS-1:0] wiper_tap, // Taps
	input wire logic [NUM_POTS-1:0] wiper_off_bit, // Off
	input wire logic [NUM_POTS-1:0] chain_enable_bit, // Chain
	input wire logic nv_busy, // Busy
	input wire logic step_mode // Step mode
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dcb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	int busy_len;
	logic [1:0] age;
	logic taps_ok;
	// Busy run length; age hides the taps until their decode has landed
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			busy_len <= 0;
			age <= 2'h0;
		end else begin
			busy_len <= nv_busy ? busy_len + 1 : 0;
			age <= (age == 2'h3) ? age : age + 2'h1;
		end
	end
	// One tap per pot, none while its wiper is off
	always_comb begin
		taps_ok = 1'b1;
		for (int p = 0; p < NUM_POTS; p++) begin
			if (wiper_off_bit[p] ? |wiper_tap[p*NUM_TAPS +: NUM_TAPS]
				: !$onehot(wiper_tap[p*NUM_TAPS +: NUM_TAPS])) begin
				taps_ok = 1'b0;
			end
		end
	end
	sequence stop_seen;
		scl_in && $rose(sda_in);
	endsequence
	sequence busy_start;
		$rose(nv_busy);
	endsequence
	a_busy_quiet: assert property (nv_busy |-> !sda_oe)
		else $error("data pulled during write cycle");
	a_busy_length: assert property ($fell(nv_busy) |->
		busy_len >= NV_CYCLES && busy_len <= NV_CYCLES + 1)
		else $error("write cycle length wrong");
	a_busy_from_stop: assert property (busy_start |-> scl_in && sda_in)
		else $error("write cycle began without stop");
	a_busy_taps_hold: assert property (nv_busy && $past(nv_busy)
		|-> $stable(wiper_tap))
		else $error("taps moved during write cycle");
	a_tap_onehot: assert property (age == 2'h3 |-> taps_ok)
		else $error("tap select not one-hot");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data changed while clock high");
	a_ack_width: assert property ($rose(sda_oe) |-> sda_oe[*7])
		else $error("pull shorter than a bit");
	a_step_ends: assert property ((step_mode ##0 stop_seen)
		|-> ##[1:5] !step_mode)
		else $error("step mode outlived stop");
endmodule

bind qpcd_decoder qpcd_decoder_chk #(.NV_CYCLES(NV_CYCLES)) u_chk (
	.core_clk(core_clk),
	.resetn(resetn),
	.scl_in(scl_in),
	.sda_in(sda_in),
	.sda_out(sda_out),
	.sda_oe(sda_oe),
	.addr_pins(addr_pins),
	.wiper_tap(wiper_tap),
	.wiper_off_bit(wiper_off_bit),
	.chain_enable_bit(chain_enable_bit),
	.nv_busy(nv_busy),
	.step_mode(step_mode)
);

// ===== qpcd_master_model.sv
// Two-wire bus master model.
// Assumes a pull-up on data; one bit takes eight core clocks.
module qpcd_master_model (
	input wire logic core_clk, // Time base
	input wire logic sda_line, // Resolved data
	output logic scl, // Clock, idles high
	output logic sda_low // Pulls data low
);
	timeunit 1ns;
	timeprecision 1ns;
	// Clock stands high between frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic q();
		repeat (2) @(negedge core_clk);
	endtask
	// Data moves only while the clock is low
	task automatic bitx(input logic b, output logic r);
		sda_low = ~b;
		q();
		scl = 1'b1;
		q();
		r = sda_line;
		q();
		scl = 1'b0;
		q();
	endtask
	task automatic start();
		sda_low = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda_low = 1'b1;
		q();
		scl = 1'b0;
		q();
	endtask
	task automatic stop();
		sda_low = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_low = 1'b0;
		q();
	endtask
	// Line is released on the ninth clock for the answer
	task automatic sendb(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(b[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask
	task automatic readb(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(1'b1, r);
	endtask
endmodule

// ===== tb_top.sv
// Self-checking bench for the pot command decoder.
// Assumes the master model file and a pulled-up data line.
module tb_top
	import qpcd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] DEV = 4'h6; // Type code, value arbitrary
	localparam int NV = 40; // Short write cycle keeps the run brief
	localparam logic [31:0] OPS = 32'h18edcba9;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] pins = 4'h3;
	logic scl;
	logic sda_low;
	logic sda_oe;
	logic sda_out;
	logic nv_busy;
	logic step_mode;
	logic [255:0] tap;
	logic [3:0] off;
	logic [3:0] chain;
	logic [31:0] rs = 32'hdce0;
	logic [7:0] wpr [4];
	logic [7:0] setr [16];
	int failures = 0;
	int n_compared = 0;
	int cyc = 0;
	wire sda = ~(sda_low | (sda_oe & ~sda_out)); // Released line reads high
	qpcd_decoder #(.DEV_TYPE(DEV), .NV_CYCLES(NV)) dut (
		.core_clk(core_clk),
		.resetn(resetn),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.addr_pins(pins),
		.wiper_tap(tap),
		.wiper_off_bit(off),
		.chain_enable_bit(chain),
		.nv_busy(nv_busy),
		.step_mode(step_mode)
	);
	qpcd_master_model m (
		.core_clk(core_clk),
		.sda_line(sda),
		.scl(scl),
		.sda_low(sda_low)
	);
	initial begin
		forever #50 core_clk = ~core_clk;
	end
	// Cycle ceiling cuts a hung handshake short
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures = failures + 1;
			report_and_stop();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [63:0] exp_tap(input logic [7:0] w);
		return w[6] ? 64'h0 : 64'h1 << w[5:0];
	endfunction
	// Steps stop at the end taps instead of wrapping
	function automatic logic [5:0] step_pos(input logic [5:0] w, input logic up);
		return up ? ((w == 6'h3f) ? w : w + 6'h1) : ((w == 6'h00) ? w : w - 6'h1);
	endfunction
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Copies settle late, so every check waits past that delay
	task automatic check_all();
		repeat (16) @(negedge core_clk);
		for (int p = 0; p < 4; p++) begin
			chk(tap[p*64 +: 64], exp_tap(wpr[p]));
			chk({chain[p], off[p]}, wpr[p][7:6]);
		end
	endtask
	task automatic poll();
		logic a;
		repeat (3) @(negedge core_clk);
		chk(nv_busy, 1'b1);
		m.start();
		m.sendb({DEV, pins}, a);
		chk(a, 1'b0);
		for (int i = 0; i < 4 && !a; i++) begin
			m.start();
			m.sendb({DEV, pins}, a);
		end
		chk(a, 1'b1);
		m.stop();
	endtask
	// One command, then the expected registers follow it
	task automatic cmd(input logic [7:0] ins, input logic [7:0] d);
		logic a;
		logic [7:0] rd;
		logic [1:0] p;
		logic [3:0] k;
		p = ins[3:2];
		k = ins[3:0];
		m.start();
		m.sendb({DEV, pins}, a);
		chk(a, 1'b1);
		m.sendb(ins, a);
		chk(a, 1'b1);
		if (ins[7:4] inside {4'h9, 4'hb}) begin
			m.readb(rd);
			chk(rd, ins[5] ? setr[k] : wpr[p]);
		end
		if (ins[7:4] inside {4'ha, 4'hc}) begin
			m.sendb(d, a);
			chk(a, 1'b1);
		end
		m.stop();
		// Copied taps must still show the old position inside the settle delay
		if (ins[7:4] inside {4'hd, 4'h1}) begin
			for (int q = 0; q < 4; q++) chk(tap[q*64 +: 64], exp_tap(wpr[q]));
		end
		case (ins[7:4])
			4'ha: wpr[p] = d;
			4'hc: setr[k] = d;
			4'hd: wpr[p] = setr[k];
			4'he: setr[k] = wpr[p];
			4'h1: for (int q = 0; q < 4; q++) wpr[q] = setr[{q[1:0], k[1:0]}];
			4'h8: for (int q = 0; q < 4; q++) setr[{q[1:0], k[1:0]}] = wpr[q];
			default: ;
		endcase
		if (ins[7:4] inside {4'hc, 4'he, 4'h8}) poll();
		check_all();
	endtask
	// The stop's own clock pulse steps once more, downwards
	task automatic step_run(input logic [1:0] p, input logic up, input int n);
		logic a;
		m.start();
		m.sendb({DEV, pins}, a);
		m.sendb({4'h2, p, 2'b00}, a);
		chk(a, 1'b1);
		for (int i = 0; i < n; i++) begin
			m.bitx(up, a);
			wpr[p][5:0] = step_pos(wpr[p][5:0], up);
		end
		chk(step_mode, 1'b1);
		m.stop();
		wpr[p][5:0] = step_pos(wpr[p][5:0], 1'b0);
		check_all();
		chk(step_mode, 1'b0);
	endtask
	task automatic report_and_stop();
		if (failures == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		logic a;
		for (int i = 0; i < 16; i++) setr[i] = 8'h00;
		for (int i = 0; i < 4; i++) wpr[i] = 8'h00;
		repeat (6) @(negedge core_clk);
		resetn = 1'b1;
		rs = lfsr(rs);
		pins = rs[3:0];
		repeat (4) @(negedge core_clk);
		check_all();
		chk({step_mode, nv_busy}, 2'b00);
		// Wrong strap nibble, then wrong type nibble
		m.start();
		m.sendb({DEV, ~pins}, a);
		chk(a, 1'b0);
		m.start();
		m.sendb({~DEV, pins}, a);
		chk(a, 1'b0);
		// Undefined opcode gets no acknowledge
		m.start();
		m.sendb({DEV, pins}, a);
		chk(a, 1'b1);
		m.sendb({4'hf, rs[3:0]}, a);
		chk(a, 1'b0);
		m.stop();
		// Each opcode but 0010 three times, random pot, register and data
		for (int i = 0; i < 24; i++) begin
			rs = lfsr(rs);
			cmd({OPS[(i % 8) * 4 +: 4], rs[3:0]}, rs[15:8]);
		end
		// Step mode against both end taps
		cmd(8'ha0, 8'h3e);
		step_run(2'd0, 1'b1, 3);
		cmd(8'hac, 8'h01);
		step_run(2'd3, 1'b0, 3);
		report_and_stop();
	end
endmodule
